// >>> hw/vhm_defs.svh
// Purpose: Constants for the velocity and homing mode controller.
// Assumes: Parameter addresses are word indices on the parameter port.
// Notes:   Speeds are in revolutions per minute.
`ifndef VHM_DEFS_SVH
`define VHM_DEFS_SVH
`define VHM_ADDR_ACT_SPEED      16'h1E10
`define VHM_ADDR_PROF_SPEED     16'h1F0C
`define VHM_ADDR_TARGET_SPEED   16'h2402
`define VHM_ADDR_MAX_RAMP       16'h2500
`define VHM_ADDR_ACCEL          16'h2501
`define VHM_ADDR_DECEL          16'h2502
`define VHM_ADDR_HOME_METHOD    16'h2503
`define VHM_ADDR_HOME_OFFSET    16'h2504
`define VHM_ADDR_HOME_SETPOS    16'h2505
`define VHM_ADDR_ZERO_POINT     16'h2506
`define VHM_ADDR_ABS_POS        16'h2507
`define VHM_SPEED_MAX           32'sd3000
`define VHM_SPEED_MIN           -32'sd3000
`define VHM_MAX_RAMP_RESET      32'h0000_0BB8
`define VHM_ACCEL_RESET         32'h0000_0001
`define VHM_DECEL_RESET         32'h0000_0001
`define VHM_RAMP_TICK_NS        1000
`define VHM_CLK_NS              20
`define VHM_RAMP_DIV            ((`VHM_RAMP_TICK_NS + `VHM_CLK_NS - 1) / `VHM_CLK_NS)
`define VHM_MODE_VELOCITY       3'h3
`define VHM_MODE_HOMING         3'h6
`define VHM_MSTAT_BUSY_BIT      0
`define VHM_MSTAT_DONE_BIT      1
`define VHM_MSTAT_VALID_BIT     2
`define VHM_MSTAT_REFUSE_BIT    3
`endif

// >>> hw/vhm_pkg.sv
// Purpose: Types for the velocity and homing mode controller.
// Assumes: Included constants header is present.
// Notes:   Types only.
package vhm_pkg;
    typedef enum logic [3:0] {
        VHM_IDLE     = 4'b0001,
        VHM_VELOCITY = 4'b0010,
        VHM_HOME_RUN = 4'b0100,
        VHM_HOME_END = 4'b1000
    } vhm_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } vhm_param_req_t;

    typedef struct packed {
        logic [2:0] mode;
        logic       start;
        logic       stop;
    } vhm_mode_ctrl_t;
endpackage

// >>> hw/vhm_ramp.sv
// Purpose: Ramp generator stepping a speed toward a limited target.
// Assumes: Step enable comes from a divider on the same clock.
// Notes:   Output speed is registered.
`timescale 1ns/1ps
`default_nettype none
module vhm_ramp
    import vhm_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk_in,
    input  wire logic               sys_rst_in,
    // Control
    input  wire logic               step_en_in,
    input  wire logic               run_in,
    input  wire logic signed [31:0] target_in,
    input  wire logic        [31:0] accel_in,
    input  wire logic        [31:0] decel_in,
    // Result
    output logic signed      [31:0] speed_out
);
    logic signed [31:0] goal;
    logic signed [31:0] diff;
    logic signed [31:0] step;
    logic               speeding_up;

    // A stopped drive ramps down to standstill rather than jumping to zero.
    always_comb
    begin
        goal        = run_in ? target_in : 32'sh0000_0000;
        diff        = goal - speed_out;
        speeding_up = (speed_out >= 0) ? (goal > speed_out) : (goal < speed_out);
        step        = speeding_up ? $signed(accel_in) : $signed(decel_in);
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            speed_out <= 32'sh0000_0000;
        else if (step_en_in)
        begin
            if (diff > step)
                speed_out <= speed_out + step;
            else if (-diff > step)
                speed_out <= speed_out - step;
            else
                speed_out <= goal;
        end
    end
endmodule
`default_nettype wire

// >>> hw/vhm_ctrl.sv
// Purpose: Velocity and homing mode control of a stepper drive.
// Assumes: Parameter port writes/reads one word per cycle; same clock.
// Notes:   Encoder speed arrives as a pin-domain value and is synchronised.
// Function
// - Velocity mode ramps using acceleration and deceleration.
// - Modes run only when operation enabled.
// - Target speed changes apply immediately while moving.
// - Velocity mode ignores positioning range limits.
// - Target limited to +-3000 and ramp maximum.
// - Actual and profile speeds readable, read-only.
// - Parameter changes act on receipt, no trigger.
// - Homing relates motor position to axis position.
// - Homing by reference movement or position setting.
// - Reference point becomes zero for absolute moves.
// - Configurable offset shifts the homed zero point.
// - New zero valid only after completed movement.
// - Other modes refused during reference movement.
// - Control words start homing; status words report.
`timescale 1ns/1ps
`default_nettype none
`include "vhm_defs.svh"
module vhm_ctrl
    import vhm_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk_in,
    input  wire logic               sys_rst_in,
    // Parameter port
    input  wire vhm_param_req_t     param_in,
    output logic             [31:0] param_rdata_out,
    output logic                    param_ack_out,
    // Process data control words
    input  wire logic               op_enabled_in,
    input  wire vhm_mode_ctrl_t     mode_ctrl_in,
    output logic             [15:0] drive_status_word_out,
    output logic             [15:0] mode_status_word_out,
    // Power stage and sensors
    input  wire logic signed [15:0] motor_speed_in,
    input  wire logic signed [31:0] motor_pos_in,
    input  wire logic               ref_reached_in,
    output logic signed      [31:0] speed_cmd_out,
    output logic                    dir_out,
    output logic signed      [31:0] abs_pos_out
);
    vhm_state_t         state_reg;
    vhm_state_t         state_next;
    logic signed [31:0] target_reg;
    logic        [31:0] max_ramp_reg;
    logic        [31:0] accel_reg;
    logic        [31:0] decel_reg;
    logic               method_reg;
    logic signed [31:0] offset_reg;
    logic signed [31:0] setpos_reg;
    logic signed [31:0] zero_reg;
    logic               zero_valid_reg;
    logic               refuse_reg;
    logic               done_reg;
    logic signed [15:0] spd_meta_reg;
    logic signed [15:0] spd_sync_reg;
    logic               ref_meta_reg;
    logic               ref_sync_reg;
    logic               en_meta_reg;
    logic               en_sync_reg;
    logic        [7:0]  div_reg;
    logic               step_en;
    logic signed [31:0] limited_target;
    logic signed [31:0] ramp_target;
    logic signed [31:0] prof_speed;
    logic signed [31:0] wval;
    logic               vel_run;

    // Pin-side speed, reference and enable inputs go through two flops before use; position is used directly.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            spd_meta_reg <= 16'sh0000;
            spd_sync_reg <= 16'sh0000;
            ref_meta_reg <= 1'b0;
            ref_sync_reg <= 1'b0;
            en_meta_reg  <= 1'b0;
            en_sync_reg  <= 1'b0;
        end
        else
        begin
            spd_meta_reg <= motor_speed_in;
            spd_sync_reg <= spd_meta_reg;
            ref_meta_reg <= ref_reached_in;
            ref_sync_reg <= ref_meta_reg;
            en_meta_reg  <= op_enabled_in;
            en_sync_reg  <= en_meta_reg;
        end
    end

    // Ramp steps come at a fixed tick so acceleration is per microsecond.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in || step_en)
            div_reg <= 8'h00;
        else
            div_reg <= div_reg + 8'h01;
    end
    assign step_en = (div_reg == 8'(`VHM_RAMP_DIV - 1));

    // Parameter writes land at once; the ramp sees them next cycle.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            target_reg   <= 32'sh0000_0000;
            max_ramp_reg <= `VHM_MAX_RAMP_RESET;
            accel_reg    <= `VHM_ACCEL_RESET;
            decel_reg    <= `VHM_DECEL_RESET;
            method_reg   <= 1'b0;
            offset_reg   <= 32'sh0000_0000;
            setpos_reg   <= 32'sh0000_0000;
        end
        else if (param_in.wr)
        begin
            case (param_in.addr)
                `VHM_ADDR_TARGET_SPEED: target_reg   <= wval;
                `VHM_ADDR_MAX_RAMP:     max_ramp_reg <= param_in.wdata;
                `VHM_ADDR_ACCEL:        accel_reg    <= param_in.wdata;
                `VHM_ADDR_DECEL:        decel_reg    <= param_in.wdata;
                `VHM_ADDR_HOME_METHOD:  method_reg   <= param_in.wdata[0];
                `VHM_ADDR_HOME_OFFSET:  offset_reg   <= param_in.wdata;
                `VHM_ADDR_HOME_SETPOS:  setpos_reg   <= param_in.wdata;
                default:                ;
            endcase
        end
    end

    // Target speed writes outside the accepted band are clamped to it.
    always_comb
    begin
        wval = $signed(param_in.wdata);
        if (wval > `VHM_SPEED_MAX)
            wval = `VHM_SPEED_MAX;
        else if (wval < `VHM_SPEED_MIN)
            wval = `VHM_SPEED_MIN;
    end

    // The ramp maximum may change at any time, so limit on use, not on write.
    always_comb
    begin
        limited_target = target_reg;
        if (target_reg > $signed(max_ramp_reg))
            limited_target = $signed(max_ramp_reg);
        else if (target_reg < -$signed(max_ramp_reg))
            limited_target = -$signed(max_ramp_reg);
    end

    // Mode sequencing.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            VHM_IDLE:
            begin
                if (en_sync_reg && mode_ctrl_in.start)
                begin
                    if (mode_ctrl_in.mode == `VHM_MODE_VELOCITY)
                        state_next = VHM_VELOCITY;
                    else if (mode_ctrl_in.mode == `VHM_MODE_HOMING)
                        state_next = method_reg ? VHM_HOME_END : VHM_HOME_RUN;
                end
            end
            VHM_VELOCITY:
            begin
                if (!en_sync_reg || mode_ctrl_in.stop)
                    state_next = VHM_IDLE;
                else if (mode_ctrl_in.start && mode_ctrl_in.mode == `VHM_MODE_HOMING)
                    state_next = method_reg ? VHM_HOME_END : VHM_HOME_RUN;
            end
            VHM_HOME_RUN:
            begin
                // Any interruption abandons the movement; it is never resumed.
                if (!en_sync_reg || mode_ctrl_in.stop)
                    state_next = VHM_IDLE;
                else if (ref_sync_reg)
                    state_next = VHM_HOME_END;
            end
            VHM_HOME_END:
                state_next = VHM_IDLE;
            default:
                state_next = VHM_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            state_reg <= VHM_IDLE;
        else
            state_reg <= state_next;
    end

    // Zero point: taken only on a completed homing.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            zero_reg       <= 32'sh0000_0000;
            zero_valid_reg <= 1'b0;
            done_reg       <= 1'b0;
        end
        else if (state_reg == VHM_HOME_END)
        begin
            if (method_reg)
                zero_reg <= motor_pos_in - setpos_reg + offset_reg;
            else
                zero_reg <= motor_pos_in + offset_reg;
            zero_valid_reg <= 1'b1;
            done_reg       <= 1'b1;
        end
        else if (state_reg == VHM_HOME_RUN)
        begin
            zero_valid_reg <= 1'b0;
            done_reg       <= 1'b0;
        end
    end

    // Mode change requests during a reference movement are flagged.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
            refuse_reg <= 1'b0;
        else if (state_reg == VHM_HOME_RUN && mode_ctrl_in.start
                 && mode_ctrl_in.mode != `VHM_MODE_HOMING)
            refuse_reg <= 1'b1;
        else if (state_reg != VHM_HOME_RUN)
            refuse_reg <= 1'b0;
    end

    assign vel_run = (state_reg == VHM_VELOCITY) && en_sync_reg;
    // Homing moves slowly toward the reference in the positive direction.
    assign ramp_target = (state_reg == VHM_HOME_RUN) ? $signed(accel_reg) : limited_target;

    vhm_ramp u_ramp
    (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .step_en_in (step_en),
        .run_in     (vel_run || (state_reg == VHM_HOME_RUN)),
        .target_in  (ramp_target),
        .accel_in   (accel_reg),
        .decel_in   (decel_reg),
        .speed_out  (prof_speed)
    );

    // Output registers; no position limit stops velocity mode.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            speed_cmd_out <= 32'sh0000_0000;
            dir_out       <= 1'b0;
            abs_pos_out   <= 32'sh0000_0000;
        end
        else
        begin
            speed_cmd_out <= prof_speed;
            dir_out       <= prof_speed[31];
            abs_pos_out   <= motor_pos_in - zero_reg;
        end
    end
    // Status words.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            drive_status_word_out <= 16'h0000;
            mode_status_word_out  <= 16'h0000;
        end
        else
        begin
            drive_status_word_out <= {12'h000, state_reg};
            mode_status_word_out  <= {12'h000, refuse_reg, zero_valid_reg,
                                      done_reg, state_reg == VHM_HOME_RUN};
        end
    end

    // Parameter reads.
    always_ff @(posedge mclk_in)
    begin
        if (sys_rst_in)
        begin
            param_rdata_out <= 32'h0000_0000;
            param_ack_out   <= 1'b0;
        end
        else
        begin
            param_ack_out <= param_in.rd || param_in.wr;
            case (param_in.addr)
                `VHM_ADDR_ACT_SPEED:    param_rdata_out <= {{16{spd_sync_reg[15]}}, spd_sync_reg};
                `VHM_ADDR_PROF_SPEED:   param_rdata_out <= prof_speed;
                `VHM_ADDR_TARGET_SPEED: param_rdata_out <= target_reg;
                `VHM_ADDR_MAX_RAMP:     param_rdata_out <= max_ramp_reg;
                `VHM_ADDR_ACCEL:        param_rdata_out <= accel_reg;
                `VHM_ADDR_DECEL:        param_rdata_out <= decel_reg;
                `VHM_ADDR_HOME_METHOD:  param_rdata_out <= {31'h0, method_reg};
                `VHM_ADDR_HOME_OFFSET:  param_rdata_out <= offset_reg;
                `VHM_ADDR_HOME_SETPOS:  param_rdata_out <= setpos_reg;
                `VHM_ADDR_ZERO_POINT:   param_rdata_out <= zero_reg;
                `VHM_ADDR_ABS_POS:      param_rdata_out <= abs_pos_out;
                default:                param_rdata_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> bench/vhm_ctrl_sva.sv
// Purpose: Port assertions for the velocity and homing controller.
// Assumes: One clock, synchronous reset active high.
// Notes:   Bound to every instance of the controller.
`timescale 1ns/1ps
`default_nettype none
`include "vhm_defs.svh"
module vhm_ctrl_sva
    import vhm_pkg::*;
(
    // Clock and reset
    input wire logic               mclk_in,
    input wire logic               sys_rst_in,
    // Watched ports
    input wire vhm_param_req_t     param_in,
    input wire logic        [31:0] param_rdata_out,
    input wire logic               param_ack_out,
    input wire logic               op_enabled_in,
    input wire vhm_mode_ctrl_t     mode_ctrl_in,
    input wire logic        [15:0] drive_status_word_out,
    input wire logic        [15:0] mode_status_word_out,
    input wire logic signed [31:0] speed_cmd_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    logic req;
    assign req = param_in.wr | param_in.rd;
    property p_ack; req |=> param_ack_out; endproperty
    a_ack: assert property (p_ack) else $error("access not acknowledged");
    property p_no_ack; !req |=> !param_ack_out; endproperty
    a_no_ack: assert property (p_no_ack) else $error("stray acknowledge");
    property p_prof;
        param_in.rd && param_in.addr == `VHM_ADDR_PROF_SPEED
            |=> param_rdata_out == speed_cmd_out;
    endproperty
    a_prof: assert property (p_prof) else $error("profile speed read wrong");
    property p_limit;
        speed_cmd_out <= `VHM_SPEED_MAX && speed_cmd_out >= `VHM_SPEED_MIN;
    endproperty
    a_limit: assert property (p_limit) else $error("speed beyond limit");
    property p_off; !op_enabled_in [*5] |-> drive_status_word_out[2:1] == 2'b00; endproperty
    a_off: assert property (p_off) else $error("mode runs while disabled");
    property p_ramp;
        drive_status_word_out[1] && $changed(speed_cmd_out)
            |=> ($stable(speed_cmd_out) || !drive_status_word_out[1]) [*8];
    endproperty
    a_ramp: assert property (p_ramp) else $error("speed stepped off tick");
    property p_refuse;
        drive_status_word_out[2] && mode_ctrl_in.start && !mode_ctrl_in.stop
            && mode_ctrl_in.mode == `VHM_MODE_VELOCITY
            |=> ##[0:1] mode_status_word_out[3] && drive_status_word_out[2];
    endproperty
    a_refuse: assert property (p_refuse) else $error("mode change not refused");
    property p_inval;
        drive_status_word_out[2] && $past(drive_status_word_out[2]) |-> !mode_status_word_out[2];
    endproperty
    a_inval: assert property (p_inval) else $error("zero valid while homing");
    property p_valid; drive_status_word_out[3] |-> ##[0:1] mode_status_word_out[2]; endproperty
    a_valid: assert property (p_valid) else $error("zero not valid at end");
    property p_end_once; drive_status_word_out[3] |=> !drive_status_word_out[3]; endproperty
    a_end_once: assert property (p_end_once) else $error("end state held");
    c_vel: cover property (drive_status_word_out[1]);
    c_end: cover property (drive_status_word_out[3]);
    c_refuse: cover property (mode_status_word_out[3]);
endmodule
bind vhm_ctrl vhm_ctrl_sva sva_u (.mclk_in, .sys_rst_in, .param_in, .param_rdata_out,
    .param_ack_out, .op_enabled_in, .mode_ctrl_in, .drive_status_word_out,
    .mode_status_word_out, .speed_cmd_out);
`default_nettype wire

// >>> bench/vhm_master.sv
// Purpose: Fieldbus master model driving parameters and control words.
// Assumes: One access per call, released after the request edge.
// Notes:   Enable changes wait out the input synchroniser.
`timescale 1ns/1ps
`default_nettype none
module vhm_master
    import vhm_pkg::*;
(
    // Clock and answer
    input  wire logic           mclk_in,
    input  wire logic           ack_in,
    input  wire logic    [31:0] rdata_in,
    // Requests and control
    output var vhm_param_req_t  req_out,
    output var vhm_mode_ctrl_t  ctrl_out,
    output logic                op_en_out
);
    initial
    begin
        req_out = '0;
        ctrl_out = '0;
        op_en_out = 1'b0;
    end
    task automatic access(input logic w, input logic [15:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_in);
        #1;
        req_out = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk_in);
        #1;
        req_out = '0;
        q = (ack_in === 1'b1) ? rdata_in : 'x;
    endtask
    // An interrupted run is never resumed: each start is a fresh request.
    task automatic pulse(input logic en, input logic [2:0] m, input logic go, input logic halt);
        op_en_out = en;
        repeat (4) @(posedge mclk_in);
        #1;
        ctrl_out = '{mode: m, start: go, stop: halt};
        @(posedge mclk_in);
        #1;
        ctrl_out = '{mode: m, start: 1'b0, stop: 1'b0};
    endtask
endmodule
`default_nettype wire

// >>> bench/velocity_and_homing_mode_control_test.sv
// Purpose: Self-checking bench for the velocity and homing controller.
// Assumes: 50 MHz clock, synchronous reset held for 16 cycles.
// Notes:   Expected values come from integer models in the bench.
`timescale 1ns/1ps
`default_nettype none
`include "vhm_defs.svh"
module velocity_and_homing_mode_control_test;
    import vhm_pkg::*;
    logic               mclk_in = 1'b0;
    logic               sys_rst_in = 1'b1;
    logic signed [15:0] mspd = '0;
    logic signed [31:0] mpos = '0;
    logic               ref_hit = 1'b0;
    vhm_param_req_t     req;
    vhm_mode_ctrl_t     ctrl;
    logic               op_en, ack, dir;
    logic        [31:0] rdata;
    logic        [15:0] dsw, msw;
    logic signed [31:0] spd, apos;
    logic        [31:0] lfsr = 32'h0000_169c;
    int                 err_total = 0;
    int                 n_compared = 0;
    int                 m_max = 3000;
    int                 t;
    always #10 mclk_in = ~mclk_in;
    vhm_master m_u (.mclk_in(mclk_in), .ack_in(ack), .rdata_in(rdata),
        .req_out(req), .ctrl_out(ctrl), .op_en_out(op_en));
    vhm_ctrl dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .param_in(req),
        .param_rdata_out(rdata), .param_ack_out(ack), .op_enabled_in(op_en),
        .mode_ctrl_in(ctrl), .drive_status_word_out(dsw), .mode_status_word_out(msw),
        .motor_speed_in(mspd), .motor_pos_in(mpos), .ref_reached_in(ref_hit),
        .speed_cmd_out(spd), .dir_out(dir), .abs_pos_out(apos));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic int clip(input int v, input int hi);
        return (v > hi) ? hi : ((v < -hi) ? -hi : v);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        m_u.access(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] e, input string w);
        logic [31:0] q;
        m_u.access(1'b0, a, '0, q);
        chk(q, e, w);
    endtask
    // Writes a target, then waits for the ramp to land on the limited value.
    task automatic vel(input int v);
        int e;
        int n;
        e = clip(v, m_max);
        wr(`VHM_ADDR_TARGET_SPEED, 32'(v));
        for (n = 0; n < 3000 && spd !== 32'(e); n++)
            #20;
        #1;
        chk(spd, 32'(e), "speed");
        if (e != 0)
            chk({31'd0, dir}, {31'd0, e < 0}, "dir");
        rdc(`VHM_ADDR_PROF_SPEED, 32'(e), "profile");
    endtask
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge mclk_in);
        #1;
        sys_rst_in = 1'b0;
        rdc(`VHM_ADDR_ACT_SPEED, 32'h0000_0000, "act reset");
        rdc(`VHM_ADDR_PROF_SPEED, 32'h0000_0000, "prof reset");
        rdc(16'h0100, 32'h0000_0000, "unmapped");
        wr(`VHM_ADDR_PROF_SPEED, rnd());
        rdc(`VHM_ADDR_PROF_SPEED, 32'h0000_0000, "prof read-only");
        for (int i = 0; i < 7; i++)
        begin
            t = (i == 0) ? 5000 : (i == 1) ? -5000 : (i == 2) ? 3000 : $signed(rnd()) % 3001;
            wr(`VHM_ADDR_TARGET_SPEED, 32'(t));
            rdc(`VHM_ADDR_TARGET_SPEED, 32'(clip(t, 3000)), "target");
        end
        mspd = 16'(rnd());
        repeat (3) @(posedge mclk_in);
        rdc(`VHM_ADDR_ACT_SPEED, 32'(mspd), "act speed");
        m_u.pulse(1'b0, `VHM_MODE_VELOCITY, 1'b1, 1'b0);
        repeat (200) @(posedge mclk_in);
        #1;
        chk(spd, 32'h0000_0000, "idle speed");
        chk({12'd0, dsw[3:0]}, 16'h0001, "idle state");
        m_max = 4;
        wr(`VHM_ADDR_MAX_RAMP, 32'h0000_0004);
        m_u.pulse(1'b1, `VHM_MODE_VELOCITY, 1'b1, 1'b0);
        vel(10);
        vel(-3);
        vel(0);
        m_u.pulse(1'b0, `VHM_MODE_VELOCITY, 1'b0, 1'b0);
        chk({14'd0, dsw[2:1]}, 16'h0000, "disabled");
        mpos = 32'sd1000;
        wr(`VHM_ADDR_HOME_METHOD, 32'h0000_0001);
        wr(`VHM_ADDR_HOME_OFFSET, 32'h0000_0007);
        wr(`VHM_ADDR_HOME_SETPOS, 32'h0000_0064);
        m_u.pulse(1'b1, `VHM_MODE_HOMING, 1'b1, 1'b0);
        repeat (6) @(posedge mclk_in);
        rdc(`VHM_ADDR_ZERO_POINT, 32'(1000 - 100 + 7), "set zero");
        chk(apos, 32'(93), "abs pos");
        wr(`VHM_ADDR_HOME_METHOD, 32'h0000_0000);
        mpos = 32'sd500;
        m_u.pulse(1'b1, `VHM_MODE_HOMING, 1'b1, 1'b0);
        // State and status words are registered: the state word trails the start by two edges, the zero-valid bit by three.
        repeat (2) @(posedge mclk_in);
        #1;
        chk({12'd0, dsw[3:0]}, 16'h0004, "home run");
        chk({15'd0, msw[2]}, 16'h0000, "zero invalid");
        m_u.pulse(1'b1, `VHM_MODE_VELOCITY, 1'b1, 1'b0);
        @(posedge mclk_in);
        #1;
        chk({15'd0, msw[3]}, 16'h0001, "refused");
        chk({12'd0, dsw[3:0]}, 16'h0004, "still homing");
        m_u.pulse(1'b1, `VHM_MODE_HOMING, 1'b0, 1'b1);
        repeat (2) @(posedge mclk_in);
        #1;
        chk({13'd0, dsw[2], msw[2], 1'b0}, 16'h0000, "abandoned");
        m_u.pulse(1'b1, `VHM_MODE_HOMING, 1'b1, 1'b0);
        ref_hit = 1'b1;
        repeat (8) @(posedge mclk_in);
        #1;
        ref_hit = 1'b0;
        mpos = 32'sd600;
        chk({14'd0, msw[2:1]}, 16'h0003, "zero valid");
        rdc(`VHM_ADDR_ZERO_POINT, 32'(500 + 7), "ref zero");
        repeat (4) @(posedge mclk_in);
        rdc(`VHM_ADDR_ABS_POS, 32'(600 - 507), "ref abs");
        chk(apos, 32'(93), "abs out");
        conclude();
    end
endmodule
`default_nettype wire
